// ### bench/ack_button_model.sv
// operator acknowledge button model
module ack_button_model (
  input wire logic mclk,
  input wire logic press,
  output logic ack_button
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_q = 2'h0;
  // -----------------------------------------------------------
  // press
  // -----------------------------------------------------------
  // a human press lasts several cycles, so hold the contact for two
  always_ff @(posedge mclk)
  begin
    hold_q <= press ? 2'h2 : ((hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0);
  end
  assign ack_button = (hold_q != 2'h0);
endmodule // ack_button_model

// ### bench/insulation_alarm_sequencer_tb.sv
// self-checking bench of the insulation alarm sequencer
module insulation_alarm_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = ins_alarm_pkg::DELAY_W;
  logic mclk = 0, rst_n = 0, prev_in = 0, ins_in = 0, press = 0, prev_ack = 1, ins_ack = 1;
  logic en = 1;
  logic [ins_alarm_pkg::DELAY_W-1:0] dly = '0;
  logic ack, p_rly, p_led, i_rly, i_led, tr;
  logic [1:0] st;
  int n_fail = 0, total_checks = 0, cyc = 0, n_tr = 0;
  always #2 mclk = ~mclk;
  ack_button_model btn (.mclk(mclk), .press(press), .ack_button(ack));
  insulation_alarm_sequencer dut (.mclk(mclk), .rst_n(rst_n), .clk_en(en),
    .below_prev_thr(prev_in), .below_ins_thr(ins_in), .ack_button(ack),
    .ins_delay_cycles(dly), .prev_relay_ack_en(prev_ack),
    .insulation_alarm_relay_setting(ins_ack), .prev_relay(p_rly), .prev_led(p_led),
    .ins_relay(i_rly), .ins_led(i_led), .transient_pulse(tr), .alarm_state(st));
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      close_out();
    end
  end
  // pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge mclk)
  begin
    if (tr === 1'b1)
      n_tr++;
  end
  task automatic cmp_n(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic to_alarm(input int n);
    int k;
    k = 0;
    dly = DW'(n);
    ins_in = 1;
    while (i_rly !== 1'b1 && k < n + 8)
    begin
      step(1);
      k++;
    end
    cmp({i_rly, i_led}, 2'h3);
    cmp(st, 2'h2);
    cmp_n(16'(k), 16'(n + 3));
  endtask
  task automatic t_prev;
    prev_in = 1;
    step(2);
    cmp({p_rly, p_led}, 2'h3);
    prev_in = 0;
    step(3);
    cmp({p_rly, p_led}, 2'h0);
  endtask
  task automatic t_ack(input logic si, input logic sp);
    int t0;
    t0 = n_tr;
    prev_in = 1;
    ins_ack = si;
    prev_ack = sp;
    to_alarm(5);
    press = 1;
    step(1);
    press = 0;
    step(4);
    cmp(st, 2'h3);
    cmp({i_rly, p_rly}, {~si, ~sp});
    ins_in = 0;
    prev_in = 0;
    step(3);
    cmp(st, 2'h0);
    cmp({i_rly, i_led}, 2'h0);
    cmp_n(16'(n_tr - t0), 16'h0000);
  endtask
  task automatic t_trans;
    int t0;
    t0 = n_tr;
    to_alarm(0);
    ins_in = 0;
    step(3);
    cmp(st, 2'h0);
    cmp({i_rly, i_led}, 2'h0);
    cmp(2'(n_tr - t0), 2'h1);
  endtask
  task automatic t_cancel;
    int t0;
    t0 = n_tr;
    dly = DW'(20);
    ins_in = 1;
    step(6);
    cmp(st, 2'h1);
    ins_in = 0;
    step(3);
    cmp(st, 2'h0);
    cmp({i_rly, i_led}, 2'h0);
    ins_in = 1;
    step(18);
    cmp({st[1], i_rly}, 2'h0);
    ins_in = 0;
    step(3);
    cmp_n(16'(n_tr - t0), 16'h0000);
  endtask
  // clock enable low must freeze the delay count and the state
  task automatic t_freeze;
    int t0;
    t0 = n_tr;
    dly = DW'(3);
    ins_in = 1;
    step(2);
    en = 0;
    step(10);
    cmp(st, 2'h1);
    en = 1;
    step(3);
    cmp({i_rly, i_led}, 2'h0);
    step(1);
    cmp({i_rly, i_led}, 2'h3);
    ins_in = 0;
    step(3);
    cmp(st, 2'h0);
    cmp_n(16'(n_tr - t0), 16'h0001);
  endtask
  // reset in mid-alarm: everything idles during and right after it
  task automatic t_reset;
    prev_in = 1;
    to_alarm(0);
    rst_n = 0;
    ins_in = 0;
    prev_in = 0;
    step(2);
    cmp({i_rly, i_led}, 2'h0);
    cmp({p_rly, p_led}, 2'h0);
    cmp(st, 2'h0);
    rst_n = 1;
    step(1);
    cmp({i_rly, p_rly}, 2'h0);
    cmp(st, 2'h0);
  endtask
  initial
  begin
    step(16);
    cmp({i_rly, p_rly}, 2'h0);
    rst_n = 1;
    step(1);
    t_prev();
    t_ack(1'b1, 1'b1);
    t_ack(1'b1, 1'b0);
    t_ack(1'b0, 1'b1);
    t_trans();
    t_cancel();
    t_freeze();
    t_reset();
    close_out();
  end
endmodule // insulation_alarm_sequencer_tb

// ### hdl/ins_alarm_pkg.sv
// constants shared by the insulation alarm sequencer
package ins_alarm_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned DELAY_W = 48;
  // delay setting is given in milliseconds
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
  localparam logic [DELAY_W-1:0] DELAY_MS_DEFAULT = 48'h0000_0000_0000;
  // longest allowed delay: 120 minutes
  localparam logic [DELAY_W-1:0] DELAY_MS_MAX = 48'h0000_006D_DD00;
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_DELAY,
    ST_ALARM,
    ST_ACKED
  } alarm_state_t;
endpackage

// ### hdl/insulation_alarm_sequencer.sv
// insulation alarm sequencing: thresholds, delay, acknowledge, transient flag

module insulation_alarm_sequencer #(
  parameter int unsigned DELAY_W = ins_alarm_pkg::DELAY_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic below_prev_thr,
  input wire logic below_ins_thr,
  input wire logic ack_button,
  input wire logic [DELAY_W-1:0] ins_delay_cycles,
  input wire logic prev_relay_ack_en,
  input wire logic insulation_alarm_relay_setting,
  output logic prev_relay,
  output logic prev_led,
  output logic ins_relay,
  output logic ins_led,
  output logic transient_pulse,
  output logic [1:0] alarm_state
);

  // elaboration check: the counter compare is not served beyond 64 bits
  if (DELAY_W < 2 || DELAY_W > 64)
  begin : g_bad_delay_w
    $error("DELAY_W must be 2..64");
  end

  ins_alarm_pkg::alarm_state_t state_q;
  logic [DELAY_W-1:0] cnt_q;
  logic ack_seen_q;
  logic prev_acked_q;

  // ---------------------------------------------------------------
  // insulation alarm state machine
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ins_alarm_pkg::ST_NORMAL;
    else if (clk_en)
    begin
      case (state_q)
        ins_alarm_pkg::ST_NORMAL:
        begin
          if (below_ins_thr)
            state_q <= ins_alarm_pkg::ST_DELAY;
        end
        ins_alarm_pkg::ST_DELAY:
        begin
          if (!below_ins_thr)
            state_q <= ins_alarm_pkg::ST_NORMAL;
          else if (cnt_q >= ins_delay_cycles)
            state_q <= ins_alarm_pkg::ST_ALARM;
        end
        ins_alarm_pkg::ST_ALARM:
        begin
          if (!below_ins_thr)
            state_q <= ins_alarm_pkg::ST_NORMAL;
          else if (ack_button)
            state_q <= ins_alarm_pkg::ST_ACKED;
        end
        ins_alarm_pkg::ST_ACKED:
        begin
          if (!below_ins_thr)
            state_q <= ins_alarm_pkg::ST_NORMAL;
        end
        default:
          state_q <= ins_alarm_pkg::ST_NORMAL;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // delay counter
  // ---------------------------------------------------------------
  // counts from ST_DELAY entry; a zero setting alarms on the edge after ST_DELAY is entered
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (clk_en)
    begin
      if (state_q == ins_alarm_pkg::ST_DELAY && below_ins_thr)
        cnt_q <= cnt_q + DELAY_W'(1);
      else
        cnt_q <= '0;
    end
  end

  // ---------------------------------------------------------------
  // acknowledge bookkeeping and transient flag
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ack_seen_q <= 1'b0;
    else if (clk_en)
    begin
      if (state_q == ins_alarm_pkg::ST_ALARM && ack_button)
        ack_seen_q <= 1'b1;
      else if (state_q == ins_alarm_pkg::ST_NORMAL)
        ack_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      transient_pulse <= 1'b0;
    else if (clk_en)
      transient_pulse <= (state_q == ins_alarm_pkg::ST_ALARM) && !below_ins_thr
                         && !ack_seen_q;
    else
      transient_pulse <= 1'b0;
  end

  // preventive relay may be acknowledged alongside the insulation alarm
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      prev_acked_q <= 1'b0;
    else if (clk_en)
    begin
      if (!below_prev_thr)
        prev_acked_q <= 1'b0;
      else if (state_q == ins_alarm_pkg::ST_ALARM && ack_button && below_ins_thr
               && prev_relay_ack_en)
        prev_acked_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // relay and indicator outputs
  // ---------------------------------------------------------------
  // relays stay energised after ack when not configured to revert
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_relay <= 1'b0;
      prev_led <= 1'b0;
      ins_relay <= 1'b0;
      ins_led <= 1'b0;
      alarm_state <= 2'h0;
    end
    else if (clk_en)
    begin
      prev_led <= below_prev_thr;
      prev_relay <= below_prev_thr && !prev_acked_q;
      ins_led <= (state_q == ins_alarm_pkg::ST_ALARM)
                 || (state_q == ins_alarm_pkg::ST_ACKED);
      ins_relay <= (state_q == ins_alarm_pkg::ST_ALARM)
                   || (state_q == ins_alarm_pkg::ST_ACKED
                       && !insulation_alarm_relay_setting);
      alarm_state <= state_q;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_prev_follow;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && below_prev_thr |=> prev_led;
  endproperty
  a_prev_follow: assert property (p_prev_follow) else $error("preventive led missing");

  property p_alarm_entry;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && state_q == ins_alarm_pkg::ST_DELAY && below_ins_thr
      && cnt_q >= ins_delay_cycles |=> state_q == ins_alarm_pkg::ST_ALARM;
  endproperty
  a_alarm_entry: assert property (p_alarm_entry) else $error("alarm not entered");

  property p_no_early;
    @(posedge mclk) disable iff (!rst_n)
      state_q == ins_alarm_pkg::ST_ALARM && $past(state_q) == ins_alarm_pkg::ST_DELAY
      |-> $past(cnt_q) >= $past(ins_delay_cycles);
  endproperty
  a_no_early: assert property (p_no_early) else $error("alarm before delay");

  property p_ack_revert;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && state_q == ins_alarm_pkg::ST_ALARM && ack_button && below_ins_thr
      && insulation_alarm_relay_setting ##1 clk_en && insulation_alarm_relay_setting
      |=> !ins_relay;
  endproperty
  a_ack_revert: assert property (p_ack_revert) else $error("relay kept after ack");

  property p_ack_hold;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && state_q == ins_alarm_pkg::ST_ACKED && below_ins_thr
      && !insulation_alarm_relay_setting |=> ins_relay;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("relay reverted");

  property p_clear;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && !below_ins_thr ##1 clk_en && !below_ins_thr |=> !ins_led;
  endproperty
  a_clear: assert property (p_clear) else $error("led stays on");

  property p_transient;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && state_q == ins_alarm_pkg::ST_ALARM && !below_ins_thr && !ack_seen_q
      |=> transient_pulse;
  endproperty
  a_transient: assert property (p_transient) else $error("transient missed");

  property p_cancel;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && state_q == ins_alarm_pkg::ST_DELAY && !below_ins_thr
      |=> state_q == ins_alarm_pkg::ST_NORMAL && cnt_q == '0;
  endproperty
  a_cancel: assert property (p_cancel) else $error("delay not cancelled");

  property p_cov_alarm;
    @(posedge mclk) disable iff (!rst_n) state_q == ins_alarm_pkg::ST_ALARM;
  endproperty
  c_cov_alarm: cover property (p_cov_alarm);

  property p_cov_ack;
    @(posedge mclk) disable iff (!rst_n) state_q == ins_alarm_pkg::ST_ACKED;
  endproperty
  c_cov_ack: cover property (p_cov_ack);

  property p_cov_trans;
    @(posedge mclk) disable iff (!rst_n) transient_pulse;
  endproperty
  c_cov_trans: cover property (p_cov_trans);

endmodule // insulation_alarm_sequencer
